/* core/sync_serial_regs.svh */
`ifndef SYNC_SERIAL_REGS_SVH
`define SYNC_SERIAL_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// register offsets (byte addresses on the plain register port)
`define SS_OFF_MODE 5'h00
`define SS_OFF_CTRL 5'h04
`define SS_OFF_BRG 5'h08
`define SS_OFF_TXBUF 5'h0c
`define SS_OFF_RXBUF 5'h10
`define SS_OFF_PINS 5'h14
`define SS_OFF_IRQ_STAT 5'h18
`define SS_OFF_IRQ_MASK 5'h1c

////////////////////////////////////////////////////////////////////////////////
// mode register fields
`define SS_MODE_FLOW_SEL 2
`define SS_MODE_EXT_CLK 3
`define SS_MODE_FLOW_DIS 4
`define SS_MODE_OPEN_DRAIN 5
`define SS_MODE_CLK_POL 6
`define SS_MODE_MSB_FIRST 7

// control register fields
`define SS_CTRL_TX_EN 0
`define SS_CTRL_TX_EMPTY 1
`define SS_CTRL_RX_EN 2
`define SS_CTRL_RX_FULL 3
`define SS_CTRL_CONT_RX 5
`define SS_CTRL_DATA_INV 6
`define SS_CTRL_LINE_INV 7
`define SS_CTRL_WMASK 8'he5

// pin configuration register fields
`define SS_PINS_SEP_FLOW 0
`define SS_PINS_RX_DIR_IN 1
`define SS_PINS_RX_LEVEL 2
`define SS_PINS_CLK_MULTI 4
`define SS_PINS_CLK_ALT 5
`define SS_PINS_WMASK 8'h33

// interrupt status and mask bits
`define SS_IRQ_TX_LOAD 0
`define SS_IRQ_TX_DONE 1
`define SS_IRQ_RX_FULL 2
`define SS_IRQ_OVERRUN 3

////////////////////////////////////////////////////////////////////////////////
// reset values
`define SS_RST_MODE 8'h00
`define SS_RST_CTRL 8'h00
`define SS_RST_BRG 10'h000
`define SS_RST_PINS 8'h02
`define SS_RST_IRQ 4'h0

// prescaler: last count of each prescaled clock (f1, f8, f32)
`define SS_PRESC_F1_LAST 5'h00
`define SS_PRESC_F8_LAST 5'h07
`define SS_PRESC_F32_LAST 5'h1f

// number of data bits per transfer, as the last bit index
`define SS_LAST_BIT 4'h7

`endif

/* core/sync_serial_pkg.sv */
package sync_serial_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // shift engine states, gray coded along idle -> lead -> trail
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_TRAIL = 2'b11
  } shift_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // pin groups
  typedef struct packed {
    logic serial_in_pin;
    logic shift_clock_pin;
    logic flow_pin;
  } pin_in_t;

  typedef struct packed {
    logic serial_out_pin;
    logic serial_out_oe;
    logic shift_clock_pin;
    logic shift_clock_oe;
    logic alt_clock_pin;
    logic alt_clock_oe;
    logic flow_pin;
    logic flow_oe;
    logic rts_sep_pin;
    logic rts_sep_oe;
  } pin_out_t;

  ////////////////////////////////////////////////////////////////////////////////
  // module state records
  typedef struct packed {
    logic [4:0] pre;
    logic [7:0] cnt;
  } div_state_t;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] q;
  } sync_state_t;

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] ctrl;
    logic [9:0] brg;
    logic [7:0] pins;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [7:0] txbuf;
    logic tx_full;
    logic [7:0] rxbuf;
    logic rx_full;
    logic [7:0] shreg;
    logic [7:0] rxsh;
    logic [3:0] bitcnt;
    shift_state_t st;
    logic rx_active;
    logic sclk;
    logic dout;
    logic ext_prev;
    logic [15:0] rdata;
  } core_state_t;

endpackage

/* core/pin_sync.sv */
module pin_sync
(
  input wire logic clk_i,
  input wire logic rst_n,
  input wire logic [2:0] d_i,
  output logic [2:0] q_o
);

  sync_serial_pkg::sync_state_t cur, nx;

  // three stage chain; a bit counts once stages two and three agree
  always_comb
  begin
    nx = cur;
    nx.s1 = d_i;
    nx.s2 = cur.s1;
    nx.s3 = cur.s2;
    for (int i = 0; i < 3; i++)
    begin
      if (cur.s2[i] == cur.s3[i])
        nx.q[i] = cur.s3[i];
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      cur <= '{s1: 3'h7, s2: 3'h7, s3: 3'h7, q: 3'h7};
    else
      cur <= nx;
  end

  assign q_o = cur.q;

endmodule

/* core/clock_divider.sv */
`include "sync_serial_regs.svh"

module clock_divider
(
  input wire logic clk_i,
  input wire logic rst_n,
  input wire logic run_i,
  input wire logic [7:0] n_i,
  input wire logic [1:0] psel_i,
  output logic tick_o
);

  sync_serial_pkg::div_state_t cur, nx;
  logic [4:0] last;

  // last prescaler count for the chosen base clock
  function automatic logic [4:0] presc_last(input logic [1:0] sel);
    case (sel)
      2'h0: presc_last = `SS_PRESC_F1_LAST;
      2'h1: presc_last = `SS_PRESC_F8_LAST;
      default: presc_last = `SS_PRESC_F32_LAST;
    endcase
  endfunction

  // one tick per half period: (n+1) prescaled clocks
  assign last = presc_last(psel_i);
  assign tick_o = run_i && (cur.pre == last) && (cur.cnt == n_i);

  // counters restart whenever the engine stops
  always_comb
  begin
    nx = cur;
    if (!run_i)
    begin
      nx.pre = 5'h00;
      nx.cnt = 8'h00;
    end
    else if (cur.pre == last)
    begin
      nx.pre = 5'h00;
      nx.cnt = (cur.cnt == n_i) ? 8'h00 : cur.cnt + 8'h01;
    end
    else
      nx.pre = cur.pre + 5'h01;
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      cur <= '{pre: 5'h00, cnt: 8'h00};
    else
      cur <= nx;
  end

  property p_tick_restart;
    @(posedge clk_i) disable iff (!rst_n)
    (tick_o && $stable(n_i) && $stable(psel_i)) |=> (cur.cnt == 8'h00 && cur.pre == 5'h00);
  endproperty
  a_tick_restart: assert property (p_tick_restart)
    else $error("divider did not restart after a tick");

endmodule

/* core/sync_serial_mode_options.sv */
`include "sync_serial_regs.svh"

// Overview of operation
// - polarity bit chooses the clock edge for shifting out and sampling.
// - format bit zero sends bit 0 first, one sends bit 7 first.
// - in continuous receive, reading the receive buffer rearms reception.
// - channel one drives its clock on one of two pins by select bit.
// - the two-pin clock choice applies only with the internal clock.
// - two-pin clock output and flow control exclude each other.
// - channel zero may place CTS and RTS on separate pins.
// - data logic bit inverts transmit buffer writes and receive buffer reads.
// - serial output idles high, or low when line inversion is set; open drain floats only the high level.
// - receive-only transfers still shift dummy data out.
// - clock pin is output with internal clock unless the two-pin choice selects the alternate pin, input with external.
// - flow disable frees the pin; otherwise select picks CTS or RTS.
// - serial input is sampled only while its direction is input.
// - transmit needs enable, loaded buffer and, when used, CTS low.
// - reception needs receive and transmit enables and a loaded buffer.
// - a byte finished before the buffer read flags overrun, no receive event.
// - internal transfer clock is prescaled clock over 2(n+1).
module sync_serial_mode_options
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [4:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_stb_i,
  input wire logic rd_stb_i,
  output logic [15:0] rdata_o,
  output logic irq_o,
  input wire sync_serial_pkg::pin_in_t pins_i,
  output sync_serial_pkg::pin_out_t pins_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  logic [1:0] rst_pipe;
  logic [2:0] pin_q;
  logic rst_n, rx_in, ext_in, flow_in;

  // two flop release of the asynchronous reset
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rst_pipe <= 2'b00;
    else
      rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign rst_n = rst_pipe[1];
  pin_sync u_sync
  (
    .clk_i(clk_i),
    .rst_n(rst_n),
    .d_i({pins_i.serial_in_pin, pins_i.shift_clock_pin, pins_i.flow_pin}),
    .q_o(pin_q)
  );
  assign rx_in = pin_q[2];
  assign ext_in = pin_q[1];
  assign flow_in = pin_q[0];

  ////////////////////////////////////////////////////////////////////////////////
  // state and decoded configuration
  sync_serial_pkg::core_state_t cur, nx;
  logic ext, pol, msb, inv, line_inv, idle_lvl, tick;
  logic multi_eff, sep_eff, flow_en, cts_use, cts_ok, rts_lvl, ext_idle_ok;
  logic start, lead_evt, trail_evt, finish, rd_rx, rx_bit;
  logic [7:0] rx_next;
  logic [15:0] read_val;

  // next value of a shift register, fed with one bit at the far end
  function automatic logic [7:0] shift_in(input logic m, input logic [7:0] v, input logic b);
    shift_in = m ? {v[6:0], b} : {b, v[7:1]};
  endfunction

  // the bit that leaves first in the chosen order
  function automatic logic out_bit(input logic m, input logic [7:0] v);
    out_bit = m ? v[7] : v[0];
  endfunction

  assign ext = cur.mode[`SS_MODE_EXT_CLK];
  assign pol = cur.mode[`SS_MODE_CLK_POL];
  assign msb = cur.mode[`SS_MODE_MSB_FIRST];
  assign inv = cur.ctrl[`SS_CTRL_DATA_INV];
  assign line_inv = cur.ctrl[`SS_CTRL_LINE_INV];
  assign idle_lvl = ~pol;

  // pin feature arbitration
  assign multi_eff = cur.pins[`SS_PINS_CLK_MULTI] & ~ext;
  assign sep_eff = cur.pins[`SS_PINS_SEP_FLOW] & ~multi_eff;
  assign flow_en = ~cur.mode[`SS_MODE_FLOW_DIS] & ~multi_eff;
  assign cts_use = flow_en & (sep_eff | ~cur.mode[`SS_MODE_FLOW_SEL]);
  assign cts_ok = ~cts_use | ~flow_in;
  assign rts_lvl = ~(cur.ctrl[`SS_CTRL_RX_EN] & ~cur.rx_full);
  assign ext_idle_ok = ~ext | (ext_in == idle_lvl);

  // transfer clock events, internal divider or external pin
  clock_divider u_div
  (
    .clk_i(clk_i),
    .rst_n(rst_n),
    .run_i((cur.st != sync_serial_pkg::ST_IDLE) && !ext),
    .n_i(cur.brg[7:0]),
    .psel_i(cur.brg[9:8]),
    .tick_o(tick)
  );
  assign lead_evt = ext ? ((ext_in != cur.ext_prev) && (ext_in != idle_lvl)) : tick;
  assign trail_evt = ext ? ((ext_in != cur.ext_prev) && (ext_in == idle_lvl)) : tick;

  // start needs enable, a loaded buffer, CTS and an idle external clock
  assign start = (cur.st == sync_serial_pkg::ST_IDLE) && cur.ctrl[`SS_CTRL_TX_EN]
                 && cur.tx_full && cts_ok && ext_idle_ok;
  assign finish = (cur.st == sync_serial_pkg::ST_TRAIL) && trail_evt
                  && (cur.bitcnt == `SS_LAST_BIT);
  assign rd_rx = rd_stb_i && (addr_i == `SS_OFF_RXBUF);
  assign rx_bit = cur.pins[`SS_PINS_RX_DIR_IN] & (rx_in ^ line_inv);
  assign rx_next = shift_in(msb, cur.rxsh, rx_bit);
  ////////////////////////////////////////////////////////////////////////////////
  // read multiplexer; unmapped offsets read zero
  always_comb
  begin
    read_val = 16'h0000;
    case (addr_i)
      `SS_OFF_MODE: read_val = {8'h00, cur.mode};
      `SS_OFF_CTRL: read_val = {8'h00, cur.ctrl[7:4], cur.rx_full, cur.ctrl[2], ~cur.tx_full,
                                cur.ctrl[0]};
      `SS_OFF_BRG: read_val = {6'h00, cur.brg};
      `SS_OFF_RXBUF: read_val = {8'h00, cur.rxbuf ^ {8{inv}}};
      `SS_OFF_PINS: read_val = {8'h00, cur.pins[7:3], rx_in, cur.pins[1:0]};
      `SS_OFF_IRQ_STAT: read_val = {12'h000, cur.irq_stat};
      `SS_OFF_IRQ_MASK: read_val = {12'h000, cur.irq_mask};
      default: read_val = 16'h0000;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////////
  // register writes, shift engine and buffer flags
  always_comb
  begin
    nx = cur;
    nx.ext_prev = ext_in;
    nx.rdata = rd_stb_i ? read_val : 16'h0000;
    if (cur.st == sync_serial_pkg::ST_IDLE)
      nx.sclk = idle_lvl;
    if (wr_stb_i)
    begin
      case (addr_i)
        `SS_OFF_MODE: nx.mode = wdata_i[7:0];
        `SS_OFF_CTRL: nx.ctrl = wdata_i[7:0] & `SS_CTRL_WMASK;
        `SS_OFF_BRG: nx.brg = wdata_i[9:0];
        `SS_OFF_PINS: nx.pins = wdata_i[7:0] & `SS_PINS_WMASK;
        `SS_OFF_IRQ_STAT: nx.irq_stat = cur.irq_stat & ~wdata_i[3:0];
        `SS_OFF_IRQ_MASK: nx.irq_mask = wdata_i[3:0];
        default: nx.mode = cur.mode;
      endcase
    end
    // shift engine
    case (cur.st)
      sync_serial_pkg::ST_IDLE:
      begin
        if (start)
        begin
          nx.shreg = cur.txbuf;
          nx.tx_full = 1'b0;
          nx.rx_active = cur.ctrl[`SS_CTRL_RX_EN];
          nx.bitcnt = 4'h0;
          nx.irq_stat[`SS_IRQ_TX_LOAD] = 1'b1;
          nx.st = sync_serial_pkg::ST_LEAD;
        end
      end
      sync_serial_pkg::ST_LEAD:
      begin
        if (lead_evt)
        begin
          nx.sclk = ~idle_lvl;
          nx.dout = out_bit(msb, cur.shreg);
          nx.st = sync_serial_pkg::ST_TRAIL;
        end
      end
      sync_serial_pkg::ST_TRAIL:
      begin
        if (trail_evt)
        begin
          nx.sclk = idle_lvl;
          nx.rxsh = rx_next;
          nx.shreg = shift_in(msb, cur.shreg, 1'b0);
          nx.bitcnt = cur.bitcnt + 4'h1;
          nx.st = sync_serial_pkg::ST_LEAD;
        end
        if (finish)
        begin
          nx.st = sync_serial_pkg::ST_IDLE;
          nx.dout = 1'b1;
          nx.irq_stat[`SS_IRQ_TX_DONE] = 1'b1;
        end
      end
      default: nx.st = sync_serial_pkg::ST_IDLE;
    endcase
    // receive buffer read clears full, rearms in continuous mode
    if (rd_rx)
    begin
      nx.rx_full = 1'b0;
      if (cur.ctrl[`SS_CTRL_CONT_RX] && cur.ctrl[`SS_CTRL_RX_EN])
        nx.tx_full = 1'b1;
    end
    // transmit buffer write; set wins over the start clear
    if (wr_stb_i && (addr_i == `SS_OFF_TXBUF))
    begin
      nx.txbuf = wdata_i[7:0] ^ {8{inv}};
      nx.tx_full = 1'b1;
    end
    // received byte lands in the buffer; set wins over the read clear
    if (finish && cur.rx_active)
    begin
      nx.rxbuf = rx_next;
      nx.rx_full = 1'b1;
      if (cur.rx_full && !rd_rx)
        nx.irq_stat[`SS_IRQ_OVERRUN] = 1'b1;
      else
        nx.irq_stat[`SS_IRQ_RX_FULL] = 1'b1;
    end
  end
  // state register
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur <= '0;
      cur.mode <= `SS_RST_MODE;
      cur.ctrl <= `SS_RST_CTRL;
      cur.brg <= `SS_RST_BRG;
      cur.pins <= `SS_RST_PINS;
      cur.irq_stat <= `SS_RST_IRQ;
      cur.irq_mask <= `SS_RST_IRQ;
      cur.sclk <= 1'b1;
      cur.dout <= 1'b1;
      cur.ext_prev <= 1'b1;
    end
    else
      cur <= nx;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign rdata_o = cur.rdata;
  assign irq_o = |(cur.irq_stat & cur.irq_mask);

  // pin drive
  always_comb
  begin
    pins_o.serial_out_pin = cur.dout ^ line_inv;
    pins_o.serial_out_oe = ~cur.mode[`SS_MODE_OPEN_DRAIN] | ~(cur.dout ^ line_inv);
    pins_o.shift_clock_pin = cur.sclk;
    pins_o.shift_clock_oe = ~ext & ~(multi_eff & cur.pins[`SS_PINS_CLK_ALT]);
    pins_o.alt_clock_pin = cur.sclk;
    pins_o.alt_clock_oe = multi_eff & cur.pins[`SS_PINS_CLK_ALT];
    pins_o.flow_pin = rts_lvl;
    pins_o.flow_oe = flow_en & ~sep_eff & cur.mode[`SS_MODE_FLOW_SEL];
    pins_o.rts_sep_pin = rts_lvl;
    pins_o.rts_sep_oe = flow_en & sep_eff;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_start;
    (cur.st == sync_serial_pkg::ST_IDLE) ##1 (cur.st == sync_serial_pkg::ST_LEAD);
  endsequence

  sequence s_last_trail;
    (cur.st == sync_serial_pkg::ST_TRAIL) && trail_evt && (cur.bitcnt == `SS_LAST_BIT);
  endsequence

  property p_start_cond;
    @(posedge clk_i) disable iff (!rst_n)
    s_start |-> ($past(cur.ctrl[`SS_CTRL_TX_EN]) && $past(cur.tx_full) && $past(cts_ok));
  endproperty
  a_start_cond: assert property (p_start_cond)
    else $error("transfer began without its start condition");
  property p_rx_arm;
    @(posedge clk_i) disable iff (!rst_n)
    s_start |-> (cur.rx_active == $past(cur.ctrl[`SS_CTRL_RX_EN]));
  endproperty
  a_rx_arm: assert property (p_rx_arm)
    else $error("reception armed without receive enable");
  property p_eight_bits;
    @(posedge clk_i) disable iff (!rst_n)
    s_last_trail |=> (cur.st == sync_serial_pkg::ST_IDLE) && cur.dout;
  endproperty
  a_eight_bits: assert property (p_eight_bits)
    else $error("transfer did not end after the eighth bit");
  property p_overrun;
    @(posedge clk_i) disable iff (!rst_n)
    (finish && cur.rx_active && cur.rx_full && !rd_rx && !wr_stb_i
      && !cur.irq_stat[`SS_IRQ_RX_FULL])
    |=> cur.irq_stat[`SS_IRQ_OVERRUN] && !cur.irq_stat[`SS_IRQ_RX_FULL]
        && (cur.rxbuf == $past(rx_next));
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not flagged or receive event raised");
  property p_first_bit;
    @(posedge clk_i) disable iff (!rst_n)
    ((cur.st == sync_serial_pkg::ST_LEAD) && lead_evt)
    |=> (cur.dout == ($past(msb) ? $past(cur.shreg[7]) : $past(cur.shreg[0])));
  endproperty
  a_first_bit: assert property (p_first_bit)
    else $error("wrong bit order on the serial output");
  property p_clk_idle;
    @(posedge clk_i) disable iff (!rst_n)
    ((cur.st == sync_serial_pkg::ST_IDLE) [*2]) |-> (cur.sclk == ~$past(pol));
  endproperty
  a_clk_idle: assert property (p_clk_idle)
    else $error("transfer clock not at its idle level");
  property p_cont_rx;
    @(posedge clk_i) disable iff (!rst_n)
    (rd_rx && cur.ctrl[`SS_CTRL_CONT_RX] && cur.ctrl[`SS_CTRL_RX_EN]) |=> cur.tx_full;
  endproperty
  a_cont_rx: assert property (p_cont_rx)
    else $error("continuous receive did not rearm");
  property p_read_inv;
    @(posedge clk_i) disable iff (!rst_n)
    rd_rx |=> (rdata_o[7:0] == ($past(cur.rxbuf) ^ {8{$past(inv)}}));
  endproperty
  a_read_inv: assert property (p_read_inv)
    else $error("receive buffer read with wrong data logic");
  property p_flow_excl;
    @(posedge clk_i) disable iff (!rst_n)
    pins_o.alt_clock_oe |-> !pins_o.flow_oe && !pins_o.rts_sep_oe && !ext;
  endproperty
  a_flow_excl: assert property (p_flow_excl)
    else $error("flow control active beside two-pin clock output");
  property p_ext_no_drive;
    @(posedge clk_i) disable iff (!rst_n)
    $rose(ext) |=> !pins_o.shift_clock_oe && !pins_o.alt_clock_oe;
  endproperty
  a_ext_no_drive: assert property (p_ext_no_drive)
    else $error("clock pin driven with external clock");
endmodule

/* tb/sync_peer.sv */
module sync_peer
(
  input wire logic clk_i,
  input wire logic arm_i,
  input wire logic pol_i,
  input wire logic msb_i,
  input wire logic hold_i,
  input wire logic [7:0] tx_i,
  input wire logic sclk_i,
  input wire logic sout_i,
  output logic sin_o,
  output logic cts_o,
  output logic [7:0] rx_o,
  output logic [3:0] n_o,
  output logic [7:0] half_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic prev;
  logic sd;
  logic [7:0] since;

  ////////////////////////////////////////////////////////////////////////////////
  // cts low while the peer can take a byte
  assign cts_o = hold_i;

  initial
  begin
    {prev, sd, since, sin_o, rx_o, n_o, half_o} = '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bit out on the leading edge, bit in on the trailing edge; the line is
  // inverted after each sampled bit so a late sample sees the wrong level, not the old bit
  always @(posedge clk_i)
  begin
    sd <= sout_i;
    since <= since + 8'h01;
    if (!arm_i)
    begin
      prev <= sclk_i;
      n_o <= 4'h0;
      sin_o <= ~sin_o;
    end
    else if (sclk_i != prev)
    begin
      prev <= sclk_i;
      since <= 8'h00;
      if (sclk_i == pol_i)
        sin_o <= msb_i ? tx_i[3'h7 - n_o[2:0]] : tx_i[n_o[2:0]];
      else
      begin
        rx_o <= {rx_o[6:0], sd};
        n_o <= n_o + 4'h1;
        half_o <= since + 8'h01;
        sin_o <= ~sin_o;
      end
    end
  end
endmodule

/* tb/sync_serial_mode_options_tb.sv */
`include "sync_serial_regs.svh"

module sync_serial_mode_options_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i, reset_n_i, wr_stb_i, rd_stb_i, irq_o, rd_d;
  logic [4:0] addr_i;
  logic [15:0] wdata_i, rdata_o;
  sync_serial_pkg::pin_in_t pi;
  sync_serial_pkg::pin_out_t po;
  logic arm, pol, msb, cts, cts_w, sin, sclk, sout, x;
  logic [7:0] ptx, rx, half, rnd, t, p, md, cx;
  logic [3:0] n;
  logic [15:0] exp_q[$];
  int n_mismatch, tests_run;

  ////////////////////////////////////////////////////////////////////////////////
  // wire levels, pull-ups where nothing drives
  assign sclk = po.shift_clock_oe ? po.shift_clock_pin : 1'b1;
  assign sout = po.serial_out_oe ? po.serial_out_pin : 1'b1;
  assign pi = {sin, sclk, cts_w};

  sync_serial_mode_options sync_serial_mode_options_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i),
    .rdata_o(rdata_o), .irq_o(irq_o), .pins_i(pi), .pins_o(po));
  sync_peer sync_peer_inst (.clk_i(clk_i), .arm_i(arm), .pol_i(pol), .msb_i(msb), .hold_i(cts),
    .tx_i(ptx), .sclk_i(sclk), .sout_i(sout), .sin_o(sin), .cts_o(cts_w), .rx_o(rx), .n_o(n),
    .half_o(half));

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic [7:0] rev8(input logic [7:0] s);
    for (int b = 0; b < 8; b++)
      rev8[b] = s[7 - b];
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] e);
    tests_run++;
    if (got !== e)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, e);
    end
  endtask

  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_stb_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_stb_i <= 1'b0;
  endtask

  // read notes its expectation; the monitor compares when the data stand
  task rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk_i);
    rd_stb_i <= 1'b1;
    addr_i <= a;
    exp_q.push_back(e);
    @(posedge clk_i);
    rd_stb_i <= 1'b0;
  endtask

  task arm_peer(input logic [7:0] d, input logic pl, input logic ms);
    arm <= 1'b0;
    ptx <= d;
    pol <= pl;
    msb <= ms;
    repeat (3) @(posedge clk_i);
    arm <= 1'b1;
  endtask

  // wait for the done interrupt, then check what the peer saw on the wire
  task done_chk(input logic [7:0] e);
    int k;
    k = 0;
    while (irq_o !== 1'b1 && k < 3000)
    begin
      @(negedge clk_i);
      k++;
    end
    repeat (2) @(posedge clk_i);
    chk(irq_o, 16'h0001);
    chk(rx, e);
    chk(n, 16'h0008);
    chk(half, 16'h0008);
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // result monitor and watchdog
  always @(posedge clk_i) rd_d <= rd_stb_i;
  always @(negedge clk_i) if (rd_d === 1'b1) chk(rdata_o, exp_q.pop_front());

  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    give_verdict;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {addr_i, wdata_i, wr_stb_i, rd_stb_i, rd_d, arm, pol, msb, cts, ptx} = '0;
    rnd = 8'h2c;
    n_mismatch = 0;
    tests_run = 0;
    reset_n_i = 1'b0;
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk({po.serial_out_pin, po.serial_out_oe}, 16'h0003);
    chk(po.shift_clock_oe, 16'h0001);
    chk({po.alt_clock_oe, po.flow_oe, po.rts_sep_oe}, 16'h0000);
    rd(`SS_OFF_BRG, 16'h0000);
    rd(`SS_OFF_IRQ_STAT, 16'h0000);
    rd(5'h02, 16'h0000);
    rd(`SS_OFF_TXBUF, 16'h0000);
    wr(`SS_OFF_IRQ_MASK, 16'h0002);
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      cts <= (i == 3);
      md = {i[1], i[0], i[2], 5'h00};
      cx = {i[2] & i[0], i[2], 6'h05};
      x = cx[7] ^ cx[6];
      t = rnd;
      rnd = lfsr(rnd);
      p = rnd;
      rnd = lfsr(rnd);
      wr(`SS_OFF_MODE, {8'h00, md});
      wr(`SS_OFF_BRG, (i == 2) ? 16'h0100 : 16'h0007);
      wr(`SS_OFF_CTRL, {8'h00, cx});
      arm_peer(p, i[0], i[1]);
      wr(`SS_OFF_TXBUF, {8'h00, t});
      if (i == 3)
      begin
        repeat (40) @(posedge clk_i);
        chk(n, 16'h0000);
        rd(`SS_OFF_IRQ_STAT, 16'h0000);
        cts <= 1'b0;
      end
      done_chk((i[1] ? t : rev8(t)) ^ {8{x}});
      rd(`SS_OFF_IRQ_STAT, 16'h0007);
      rd(`SS_OFF_RXBUF, {8'h00, p ^ {8{x}}});
      wr(`SS_OFF_IRQ_STAT, 16'h000f);
      @(negedge clk_i);
      chk(po.shift_clock_pin, {15'h0000, ~i[0]});
      chk({po.serial_out_pin, po.serial_out_oe}, {14'h0000, ~cx[7], ~i[2] | cx[7]});
    end
    $display("test formats done");
    wr(`SS_OFF_MODE, 16'h0000);
    wr(`SS_OFF_BRG, 16'h0007);
    wr(`SS_OFF_CTRL, 16'h0025);
    arm_peer(p, 1'b0, 1'b0);
    wr(`SS_OFF_TXBUF, {8'h00, t});
    done_chk(rev8(t));
    wr(`SS_OFF_IRQ_STAT, 16'h000f);
    arm_peer(p, 1'b0, 1'b0);
    rd(`SS_OFF_RXBUF, {8'h00, p});
    done_chk(rev8(t));
    rd(`SS_OFF_IRQ_STAT, 16'h0007);
    wr(`SS_OFF_IRQ_STAT, 16'h000f);
    p = rnd;
    arm_peer(p, 1'b0, 1'b0);
    wr(`SS_OFF_TXBUF, {8'h00, t});
    done_chk(rev8(t));
    rd(`SS_OFF_IRQ_STAT, 16'h000b);
    wr(`SS_OFF_CTRL, 16'h0005);
    rd(`SS_OFF_RXBUF, {8'h00, p});
    wr(`SS_OFF_IRQ_MASK, 16'h0000);
    @(negedge clk_i);
    chk(irq_o, 16'h0000);
    wr(`SS_OFF_IRQ_MASK, 16'h0008);
    @(negedge clk_i);
    chk(irq_o, 16'h0001);
    wr(`SS_OFF_IRQ_STAT, 16'h0008);
    @(negedge clk_i);
    chk(irq_o, 16'h0000);
    rd(`SS_OFF_IRQ_MASK, 16'h0008);
    $display("test continuous done");
    wr(`SS_OFF_MODE, 16'h0004);
    @(negedge clk_i);
    chk({po.flow_oe, po.flow_pin}, 16'h0002);
    wr(`SS_OFF_MODE, 16'h0014);
    @(negedge clk_i);
    chk(po.flow_oe, 16'h0000);
    wr(`SS_OFF_MODE, 16'h0000);
    wr(`SS_OFF_PINS, 16'h0003);
    @(negedge clk_i);
    chk(po.rts_sep_oe, 16'h0001);
    wr(`SS_OFF_PINS, 16'h0033);
    @(negedge clk_i);
    chk({po.alt_clock_oe, po.shift_clock_oe, po.rts_sep_oe}, 16'h0004);
    wr(`SS_OFF_PINS, 16'h0013);
    @(negedge clk_i);
    chk({po.alt_clock_oe, po.shift_clock_oe}, 16'h0001);
    wr(`SS_OFF_PINS, 16'h0033);
    wr(`SS_OFF_MODE, 16'h0008);
    @(negedge clk_i);
    chk({po.alt_clock_oe, po.shift_clock_oe}, 16'h0000);
    rd(`SS_OFF_MODE, 16'h0008);
    repeat (2) @(posedge clk_i);
    $display("test pins done");
    give_verdict;
  end
endmodule
